// ---- rtl/pciu_regs.vh ----
`ifndef PCIU_REGS_VH
`define PCIU_REGS_VH
// ***************************************************************
// Register offsets.
// ***************************************************************
`define PCIU_IDX_CTRL     8'h68
`define PCIU_IDX_MASK0    8'h6B
`define PCIU_IDX_MASK1    8'h6C
`define PCIU_IDX_MASK2    8'h6D
`define PCIU_IDX_MASK3    8'h73
`define PCIU_IDX_FLAGS    8'h74
`define PCIU_IDX_GIE      8'h75
`define PCIU_IDX_INT_EN   8'h76
`define PCIU_IDX_INT_CLR  8'h77
`define PCIU_IDX_PINS     8'h78
// ***************************************************************
// Field layout and reset values.
// ***************************************************************
`define PCIU_GROUPS       4
`define PCIU_GRP_W        8
`define PCIU_RST_BYTE     8'h00
`define PCIU_RST_NIB      4'h0
`endif

// ---- rtl/pciu_edge.v ----
`timescale 1ns/1ps
// ***************************************************************
// Change detector for one group of eight pins.
// ***************************************************************
module pciu_edge (
  input  wire       pclk,
  input  wire       presetn,
  input  wire [7:0] pins,
  input  wire [7:0] mask,
  input  wire       grp_en,
  output reg  [7:0] pin_q,
  output wire       change
);
  reg [7:0] pin_d;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_d <= 8'h00;
      pin_q <= 8'h00;
    end else begin
      pin_d <= pins;
      pin_q <= pin_d;
    end
  end

  // Only pins whose mask bit and group enable are set count.
  assign change = grp_en & (|((pin_d ^ pin_q) & mask));
endmodule

// ---- rtl/pciu_apb.v ----
`timescale 1ns/1ps
// ***************************************************************
// APB slave decode with zero wait states.
// ***************************************************************
module pciu_apb (
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  output wire        wr_stb,
  output wire        rd_stb,
  output wire [7:0]  idx,
  output wire        aligned
);
  assign aligned = (paddr[1:0] == 2'h0) & (paddr[11:10] == 2'h0);
  assign idx     = paddr[9:2];
  assign wr_stb  = psel & penable & pwrite;
  assign rd_stb  = psel & penable & ~pwrite;
endmodule

// ---- rtl/pciu_top.v ----
`timescale 1ns/1ps
// Operation
// - Control low nibble enables groups with global enable.
// - Groups cover pins 31:24, 23:16, 15:8, 7:0.
// - Each group has its own vector request.
// - Change on group sets its flag bit.
// - Flag plus enables raises the group vector.
// - Vector acknowledge clears the group flag.
// - Writing one clears flag, zero leaves it.
// - Per-pin mask bit and group enable gate detection.
// - Cleared mask bit excludes the pin from change detection; the PINS register still reads it.
// - Change sensing independent of outputs, clocked generation.
// - Output-driven pins still trigger change interrupts.
`include "pciu_regs.vh"
module pciu_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [31:0] change_sense_pins,
  input  wire [3:0]  vector_ack,
  output reg         group0_vector,
  output reg         group1_vector,
  output reg         group2_vector,
  output reg         group3_vector,
  output reg         irq
);
  // ***************************************************************
  // Registers and state.
  // ***************************************************************
  reg  [3:0]  group_enable_control;
  reg  [7:0]  mask_group0;
  reg  [7:0]  mask_group1;
  reg  [7:0]  mask_group2;
  reg  [7:0]  mask_group3;
  reg  [3:0]  group_change_flags;
  reg         gie;
  reg  [3:0]  int_status;
  reg  [3:0]  int_enable;
  wire [3:0]  change;
  wire [31:0] pin_q;
  wire        wr_stb;
  wire        rd_stb;
  wire [7:0]  idx;
  wire        aligned;
  reg  [3:0]  next_flags;
  reg  [3:0]  next_status;
  reg  [31:0] next_rdata;
  reg         next_err;
  wire [3:0]  wr_clr;
  wire [3:0]  int_clr;

  pciu_apb u_apb (
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .wr_stb  (wr_stb),
    .rd_stb  (rd_stb),
    .idx     (idx),
    .aligned (aligned)
  );

  // ***************************************************************
  // Change detection per group.
  // ***************************************************************
  // Pins are sampled whatever their direction, so self-driven
  // toggles also register.
  pciu_edge u_g0 (
    .pclk    (pclk),
    .presetn (presetn),
    .pins    (change_sense_pins[7:0]),
    .mask    (mask_group0),
    .grp_en  (group_enable_control[0]),
    .pin_q   (pin_q[7:0]),
    .change  (change[0])
  );
  pciu_edge u_g1 (
    .pclk    (pclk),
    .presetn (presetn),
    .pins    (change_sense_pins[15:8]),
    .mask    (mask_group1),
    .grp_en  (group_enable_control[1]),
    .pin_q   (pin_q[15:8]),
    .change  (change[1])
  );
  pciu_edge u_g2 (
    .pclk    (pclk),
    .presetn (presetn),
    .pins    (change_sense_pins[23:16]),
    .mask    (mask_group2),
    .grp_en  (group_enable_control[2]),
    .pin_q   (pin_q[23:16]),
    .change  (change[2])
  );
  pciu_edge u_g3 (
    .pclk    (pclk),
    .presetn (presetn),
    .pins    (change_sense_pins[31:24]),
    .mask    (mask_group3),
    .grp_en  (group_enable_control[3]),
    .pin_q   (pin_q[31:24]),
    .change  (change[3])
  );

  // ***************************************************************
  // Flag and status update; a new change wins over a clear.
  // ***************************************************************
  function is_wr;
    input [7:0] a;
    input [7:0] b;
    begin
      is_wr = wr_stb & aligned & (a == b);
    end
  endfunction

  assign wr_clr  = is_wr(idx, `PCIU_IDX_FLAGS) ? pwdata[3:0] : 4'h0;
  assign int_clr = is_wr(idx, `PCIU_IDX_INT_CLR) ? pwdata[3:0] : 4'h0;

  always @* begin
    next_flags  = (group_change_flags & ~wr_clr & ~vector_ack) | change;
    next_status = (int_status & ~int_clr) | change;
  end

  // ***************************************************************
  // Read data mux.
  // ***************************************************************
  always @* begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    if (!aligned) begin
      next_err = 1'b1;
    end else begin
      case (idx)
        `PCIU_IDX_CTRL:    next_rdata = {28'h0, group_enable_control};
        `PCIU_IDX_MASK0:   next_rdata = {24'h0, mask_group0};
        `PCIU_IDX_MASK1:   next_rdata = {24'h0, mask_group1};
        `PCIU_IDX_MASK2:   next_rdata = {24'h0, mask_group2};
        `PCIU_IDX_MASK3:   next_rdata = {24'h0, mask_group3};
        `PCIU_IDX_FLAGS:   next_rdata = {28'h0, group_change_flags};
        `PCIU_IDX_GIE:     next_rdata = {31'h0, gie};
        `PCIU_IDX_INT_EN:  next_rdata = {28'h0, int_enable};
        `PCIU_IDX_INT_CLR: next_rdata = {28'h0, int_status};
        `PCIU_IDX_PINS:    next_rdata = pin_q;
        default:           next_err   = 1'b1;
      endcase
    end
  end

  // ***************************************************************
  // Group enable control register.
  // ***************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group_enable_control <= `PCIU_RST_NIB;
    end else if (is_wr(idx, `PCIU_IDX_CTRL)) begin
      group_enable_control <= pwdata[3:0];
    end
  end

  // ***************************************************************
  // Pin mask registers.
  // ***************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_group0 <= `PCIU_RST_BYTE;
    end else if (is_wr(idx, `PCIU_IDX_MASK0)) begin
      mask_group0 <= pwdata[7:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_group1 <= `PCIU_RST_BYTE;
    end else if (is_wr(idx, `PCIU_IDX_MASK1)) begin
      mask_group1 <= pwdata[7:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_group2 <= `PCIU_RST_BYTE;
    end else if (is_wr(idx, `PCIU_IDX_MASK2)) begin
      mask_group2 <= pwdata[7:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_group3 <= `PCIU_RST_BYTE;
    end else if (is_wr(idx, `PCIU_IDX_MASK3)) begin
      mask_group3 <= pwdata[7:0];
    end
  end

  // ***************************************************************
  // Global and interrupt enables.
  // ***************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gie <= 1'b0;
    end else if (is_wr(idx, `PCIU_IDX_GIE)) begin
      gie <= pwdata[0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_enable <= `PCIU_RST_NIB;
    end else if (is_wr(idx, `PCIU_IDX_INT_EN)) begin
      int_enable <= pwdata[3:0];
    end
  end

  // ***************************************************************
  // Sticky flags and status.
  // ***************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group_change_flags <= `PCIU_RST_NIB;
      int_status         <= `PCIU_RST_NIB;
    end else begin
      group_change_flags <= next_flags;
      int_status         <= next_status;
    end
  end

  // ***************************************************************
  // Bus response.
  // ***************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & next_err;
      prdata  <= (psel & ~penable & ~pwrite) ? next_rdata : 32'h0000_0000;
    end
  end

  // ***************************************************************
  // Group vector requests.
  // ***************************************************************
  // Each group drives its own vector request.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group0_vector <= 1'b0;
    end else begin
      group0_vector <= next_flags[0] & gie & group_enable_control[0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group1_vector <= 1'b0;
    end else begin
      group1_vector <= next_flags[1] & gie & group_enable_control[1];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group2_vector <= 1'b0;
    end else begin
      group2_vector <= next_flags[2] & gie & group_enable_control[2];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group3_vector <= 1'b0;
    end else begin
      group3_vector <= next_flags[3] & gie & group_enable_control[3];
    end
  end

  // ***************************************************************
  // Interrupt output.
  // ***************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_status & int_enable);
    end
  end
endmodule

// ---- dv/pciu_chk.sv ----
`timescale 1ns/1ps
// ********
// Port checker.
// ********
module pciu_chk (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic        pready,
  input logic        pslverr,
  input logic [31:0] prdata,
  input logic [31:0] change_sense_pins,
  input logic [3:0]  vector_ack,
  input logic        group0_vector,
  input logic        group1_vector,
  input logic        group3_vector
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_ERR_RDY: assert property (pslverr |-> pready)
    else $error("slave error outside access");
  AST_RD_IDLE: assert property (!pready |-> prdata == 32'h00000000)
    else $error("read data outside access");
  AST_RDY_SETUP: assert property (pready |-> $past(psel && !penable))
    else $error("ready without setup");
  AST_RDY_ONE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_RISE0: assert property ($rose(group0_vector) |->
    $past(change_sense_pins[7:0], 5) != change_sense_pins[7:0] || $past(pwrite && pready)
    || $past(pwrite && pready, 2)) else $error("group 0 vector without cause");
  AST_RISE3: assert property ($rose(group3_vector) |->
    $past(change_sense_pins[31:24], 5) != change_sense_pins[31:24] || $past(pwrite && pready)
    || $past(pwrite && pready, 2)) else $error("group 3 vector without cause");
  AST_ACK0: assert property (vector_ack[0] && $stable(change_sense_pins) &&
    $past(change_sense_pins, 2) == change_sense_pins && $past(change_sense_pins, 3) ==
    change_sense_pins |-> ##[1:2] !group0_vector) else $error("group 0 vector kept");
  AST_ACK1: assert property (vector_ack[1] && $stable(change_sense_pins) &&
    $past(change_sense_pins, 2) == change_sense_pins && $past(change_sense_pins, 3) ==
    change_sense_pins |-> ##[1:2] !group1_vector) else $error("group 1 vector kept");
endmodule

// ---- dv/pciu_pins.sv ----
`timescale 1ns/1ps
// ********
// Pin and handler model.
// ********
module pciu_pins (
  input  logic        pclk,
  input  logic [31:0] level,
  input  logic [3:0]  vec,
  input  logic        ack_on,
  output logic [31:0] pins,
  output logic [3:0]  ack
);
  initial begin
    pins = 32'h00000000;
    ack = 4'h0;
  end
  always @(posedge pclk) begin
    pins <= level;
    ack <= ack_on ? (vec & ~ack) : 4'h0;
  end
endmodule

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`include "pciu_regs.vh"
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, ack_on, err;
  logic        v0, v1, v2, v3;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, level, pins, q;
  logic [3:0]  ack, vec;
  int          fail_count, n_compared;
  assign vec = {v3, v2, v1, v0};
  pciu_top pciu_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .change_sense_pins(pins), .vector_ack(ack), .group0_vector(v0),
    .group1_vector(v1), .group2_vector(v2), .group3_vector(v3), .irq(irq));
  pciu_pins pciu_pins_inst (.pclk(pclk), .level(level), .vec(vec), .ack_on(ack_on),
    .pins(pins), .ack(ack));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // ********
  // Shared tasks.
  // ********
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task xfer(input logic w, input logic [7:0] i, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task flip(input int b);
    @(posedge pclk);
    level <= level ^ (32'h00000001 << b);
    repeat (6) @(posedge pclk);
  endtask
  function logic [7:0] midx(input int g);
    midx = (g == 3) ? `PCIU_IDX_MASK3 : `PCIU_IDX_MASK0 + g[7:0];
  endfunction
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ********
  // Scenarios.
  // ********
  task t_regs;
    for (int g = 0; g < 4; g++) begin
      xfer(1'b0, midx(g), 32'h00000000);
      chk("mask reset", 32'h00000000, q);
    end
    xfer(1'b1, `PCIU_IDX_CTRL, 32'h000000FF);
    xfer(1'b0, `PCIU_IDX_CTRL, 32'h00000000);
    chk("ctrl", 32'h0000000F, q);
    xfer(1'b0, `PCIU_IDX_FLAGS, 32'h00000000);
    chk("flags", 32'h00000000, q);
    xfer(1'b1, `PCIU_IDX_CTRL, 32'h00000000);
    xfer(1'b0, 8'h70, 32'h00000000);
    chk("unmapped", 32'h00000001, {31'h0, err});
  endtask
  task t_grp(input int g);
    logic [31:0] f;
    f = 32'h00000001 << g;
    xfer(1'b1, midx(g), 32'h00000001);
    xfer(1'b1, `PCIU_IDX_CTRL, f);
    flip(8 * g + 1);
    xfer(1'b0, `PCIU_IDX_FLAGS, 32'h00000000);
    chk("flags masked", 32'h00000000, q);
    flip(8 * g);
    xfer(1'b0, `PCIU_IDX_FLAGS, 32'h00000000);
    chk("flags set", f, q);
    chk("vectors", f, {28'h0, vec});
    chk("irq off", 32'h00000000, {31'h0, irq});
    xfer(1'b1, `PCIU_IDX_INT_EN, 32'h0000000F);
    xfer(1'b1, `PCIU_IDX_GIE, 32'h00000000);
    chk("irq on", 32'h00000001, {31'h0, irq});
    repeat (2) @(posedge pclk);
    chk("vectors gie", 32'h00000000, {28'h0, vec});
    xfer(1'b1, `PCIU_IDX_INT_CLR, 32'h0000000F);
    xfer(1'b1, `PCIU_IDX_GIE, 32'h00000001);
    chk("irq clr", 32'h00000000, {31'h0, irq});
    xfer(1'b1, `PCIU_IDX_INT_EN, 32'h00000000);
    chk("vectors back", f, {28'h0, vec});
    xfer(1'b1, `PCIU_IDX_FLAGS, ~f);
    xfer(1'b0, `PCIU_IDX_FLAGS, 32'h00000000);
    chk("flags kept", f, q);
    xfer(1'b1, `PCIU_IDX_FLAGS, f);
    xfer(1'b0, `PCIU_IDX_FLAGS, 32'h00000000);
    chk("flags w1c", 32'h00000000, q);
    ack_on <= 1'b1;
    flip(8 * g);
    xfer(1'b0, `PCIU_IDX_FLAGS, 32'h00000000);
    chk("flags ack", 32'h00000000, q);
    ack_on <= 1'b0;
    xfer(1'b1, `PCIU_IDX_CTRL, 32'h00000000);
    flip(8 * g);
    xfer(1'b0, `PCIU_IDX_FLAGS, 32'h00000000);
    chk("flags off", 32'h00000000, q);
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    level = 32'h00000000;
    ack_on = 1'b0;
    fail_count = 0;
    n_compared = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    xfer(1'b1, `PCIU_IDX_GIE, 32'h00000001);
    for (int g = 0; g < 4; g++) t_grp(g);
    xfer(1'b0, `PCIU_IDX_PINS, 32'h00000000);
    chk("pins", level, q);
    xfer(1'b0, `PCIU_IDX_GIE, 32'h00000000);
    chk("gie", 32'h00000001, q);
    xfer(1'b0, `PCIU_IDX_INT_CLR, 32'h00000000);
    chk("status", 32'h00000008, q);
    test_done;
  end
  initial begin
    repeat (8000) @(posedge pclk);
    fail_count++;
    test_done;
  end
endmodule
bind pciu_top pciu_chk pciu_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .change_sense_pins(change_sense_pins), .vector_ack(vector_ack),
  .group0_vector(group0_vector), .group1_vector(group1_vector), .group3_vector(group3_vector));
